// ### verilog/power_coord_regs.vh
// Purpose: constants for the package power coordinator
// Assumes: bus clock at 100 MHz
// Notes: core and package state encodings, hint setting layout, timing
`ifndef POWER_COORD_REGS_VH
`define POWER_COORD_REGS_VH
// core idle states (3 bits)
`define CST_C0 3'h0
`define CST_C1_HALT 3'h1
`define CST_C1_WAIT 3'h2
`define CST_C2 3'h3
`define CST_C3 3'h4
`define CST_C4 3'h5
// package states (3 bits)
`define PKG_NORMAL 3'h0
`define PKG_STOP_GRANT 3'h1
`define PKG_STOP_GRANT_SNOOP 3'h2
`define PKG_SLEEP 3'h3
`define PKG_DEEP_SLEEP 3'h4
`define PKG_DEEPER_SLEEP 3'h5
// idle level read selectors (2 bits)
`define LVL_2 2'h0
`define LVL_3 2'h1
`define LVL_4 2'h2
// hint setting: three 3-bit fields, one per level read
`define HINT_LVL2_LSB 0
`define HINT_LVL3_LSB 3
`define HINT_LVL4_LSB 6
`define HINT_RESET 9'h1a3
// stop grant deadline after acknowledge response
`define STOP_GRANT_CLOCKS 20
`define STOP_GRANT_DELAY 5'h02
`endif

// ### verilog/core_idle_tracker.v
// Purpose: idle state tracking for one core
// Assumes: requests are one-cycle pulses from same-clock logic
// Notes: level reads are mapped through a programmable hint setting
`timescale 1ns/100ps
`default_nettype none
`include "power_coord_regs.vh"
module core_idle_tracker (
   input wire clk,
   input wire srst,
   input wire halt_req,
   input wire wait_req,
   input wire [2:0] wait_hint,
   input wire lvl_req,
   input wire [1:0] lvl_sel,
   input wire [8:0] hint_cfg,
   input wire wake,
   output reg [2:0] state
);
   reg [2:0] lvl_hint;
   reg [2:0] next_state;

   // hints past the deepest state fall back to C4
   function [2:0] clamp_state;
      input [2:0] s;
      begin
         clamp_state = (s > `CST_C4) ? `CST_C4 : s;
      end
   endfunction

   // level read picks its hint from the setting
   always @* begin
      case (lvl_sel)
         `LVL_2: lvl_hint = hint_cfg[`HINT_LVL2_LSB +: 3];
         `LVL_3: lvl_hint = hint_cfg[`HINT_LVL3_LSB +: 3];
         default: lvl_hint = hint_cfg[`HINT_LVL4_LSB +: 3];
      endcase
   end

   // wake beats any request; no monitor arming needed
   always @* begin
      next_state = state;
      if (wake) begin
         next_state = `CST_C0;
      end else if (state == `CST_C0) begin
         if (halt_req) begin
            next_state = `CST_C1_HALT;
         end else if (wait_req) begin
            next_state = clamp_state(wait_hint);
         end else if (lvl_req) begin
            // converted internally, no bus read cycle
            next_state = clamp_state(lvl_hint);
         end
      end
   end

   always @(posedge clk) begin
      if (srst) begin
         state <= `CST_C0;
      end else begin
         state <= next_state;
      end
   end
endmodule // core_idle_tracker
`default_nettype wire

// ### verilog/pkg_state_mapper.v
// Purpose: combine two core states into a target package state
// Assumes: core states use the codes of the constants header
// Notes: pure combinational lookup
`timescale 1ns/100ps
`default_nettype none
`include "power_coord_regs.vh"
module pkg_state_mapper (
   input wire [2:0] core0,
   input wire [2:0] core1,
   output reg [2:0] target
);
   reg [2:0] shallow;

   // shallower core sets the package level
   always @* begin
      shallow = (core0 < core1) ? core0 : core1;
      case (shallow)
         `CST_C2: target = `PKG_STOP_GRANT;
         `CST_C3: target = `PKG_DEEP_SLEEP;
         `CST_C4: target = `PKG_DEEPER_SLEEP;
         default: target = `PKG_NORMAL;
      endcase
   end
endmodule // pkg_state_mapper
`default_nettype wire

// ### verilog/dual_cpu_package_power_coordinator.v
// Purpose: coordinate two cores' idle states into one package state
// Assumes: request pulses from core logic on CLK; chipset pins async
// Notes: level read request to the chipset is a one-cycle pulse
//
// Contract
// - each core enters halt, wait C1, C2, C3 and C4 on its own.
// - the package machine has Normal, Stop Grant, Stop Grant Snoop, Sleep, Deep Sleep and Deeper Sleep.
// - when both cores share a low state, a matching level read goes to the chipset.
// - the shallower core picks Normal, Stop Grant, Deep Sleep or Deeper Sleep.
// - idle is requested by the hinted wait instruction or by level reads.
// - a level read becomes a wait request inside and is no bus read cycle.
// - level reads work without an armed monitor address.
// - the hint for each level read comes from a programmable setting.
// - a break event during stop clock asserts the pending break output.
// - system logic returns the package to Normal and cores go back to C0.
// - each core reaches Stop Grant within 20 clocks of its acknowledge response.
// - masked latched interrupts also assert the pending break output.
// - a core in C2 issues no stop grant acknowledge without stop clock.
`timescale 1ns/100ps
`default_nettype none
`include "power_coord_regs.vh"
module dual_cpu_package_power_coordinator (
   input wire CLK,
   input wire SRST,
   input wire [1:0] HALT_REQ,
   input wire [1:0] WAIT_REQ,
   input wire [5:0] WAIT_HINT,
   input wire [1:0] LVL_REQ,
   input wire [3:0] LVL_SEL,
   input wire [8:0] HINT_CFG,
   input wire [1:0] BREAK_EVENT,
   input wire [1:0] MASKED_IRQ,
   input wire [1:0] CORE_WAKE,
   input wire [1:0] ACK_RESPONSE,
   input wire STOP_CLOCK_REQUEST_N,
   input wire SLEEP_N,
   input wire SNOOP,
   output reg PENDING_BREAK_EVENT_N,
   output reg IDLE_LEVEL_READ,
   output reg [1:0] IDLE_LEVEL_SEL,
   output reg [1:0] STOP_GRANT_ACK,
   output reg [1:0] CORE_STOP_GRANTED,
   output reg [2:0] PKG_STATE,
   output reg [5:0] CORE_STATE
);
   // two-flop synchronisers for chipset pins
   // stop clock, sleep and snoop come from the chipset with no
   // relation to our clock, so nothing reads the first flop.
   // the cost is two cycles of latency on every pin edge; the
   // stop grant deadline counts from the acknowledge response,
   // so that latency never eats into it.
   // pins are folded to active high here and nowhere else.
   reg [2:0] pin_meta;
   reg [2:0] pin_sync;
   wire stop_clk;
   wire sleep_act;
   wire snoop_act;

   always @(posedge CLK) begin
      if (SRST) begin
         pin_meta <= 3'h0;
         pin_sync <= 3'h0;
      end else begin
         pin_meta <= {SNOOP, ~SLEEP_N, ~STOP_CLOCK_REQUEST_N};
         pin_sync <= pin_meta;
      end
   end
   assign stop_clk = pin_sync[0];
   assign sleep_act = pin_sync[1];
   assign snoop_act = pin_sync[2];

   // package machine state
   // pkg is the live package state, target what the two cores
   // agree on right now, last_target the target of one cycle ago.
   // pbe is the internal pending break flag; the pin copy lags it
   // by one register so the output comes straight from a flop.
   // st0 and st1 are the live core states from the trackers.
   reg [2:0] pkg;
   reg [2:0] next_pkg;
   reg [2:0] last_target;
   reg pbe;
   wire [2:0] target;
   wire [2:0] st0;
   wire [2:0] st1;
   wire [1:0] wake;

   // a pending break wakes both cores, package leaves first
   // the wake is held back until pkg reads Normal so that no core
   // runs while the package still sits in a stopped state.
   // a wake from core logic passes straight through; it only
   // moves a core, and the package follows through the target.
   // limitation: a break wakes both cores, not only the one hit.
   assign wake = CORE_WAKE | {2{pbe & (pkg == `PKG_NORMAL)}};

   // one tracker per core; both share the hint setting.
   // the cores never look at each other, which keeps their
   // idle entry independent; only the mapper combines them.
   core_idle_tracker u_core0 (
      .clk(CLK),
      .srst(SRST),
      .halt_req(HALT_REQ[0]),
      .wait_req(WAIT_REQ[0]),
      .wait_hint(WAIT_HINT[2:0]),
      .lvl_req(LVL_REQ[0]),
      .lvl_sel(LVL_SEL[1:0]),
      .hint_cfg(HINT_CFG),
      .wake(wake[0]),
      .state(st0)
   );

   core_idle_tracker u_core1 (
      .clk(CLK),
      .srst(SRST),
      .halt_req(HALT_REQ[1]),
      .wait_req(WAIT_REQ[1]),
      .wait_hint(WAIT_HINT[5:3]),
      .lvl_req(LVL_REQ[1]),
      .lvl_sel(LVL_SEL[3:2]),
      .hint_cfg(HINT_CFG),
      .wake(wake[1]),
      .state(st1)
   );

   pkg_state_mapper u_map (
      .core0(st0),
      .core1(st1),
      .target(target)
   );

   // map a package state to the chipset level read selector
   // Stop Grant asks for level 2, Deep Sleep for level 3 and
   // Deeper Sleep for level 4; Normal never issues a read, so
   // its value here is only a harmless default.
   function [1:0] lvl_of;
      input [2:0] p;
      begin
         case (p)
            `PKG_DEEP_SLEEP: lvl_of = `LVL_3;
            `PKG_DEEPER_SLEEP: lvl_of = `LVL_4;
            default: lvl_of = `LVL_2;
         endcase
      end
   endfunction

   // level read request on each change of agreed target
   // the read is a single-cycle pulse with the selector beside it.
   // a change back to Normal issues nothing: leaving a low state
   // is driven by the break path, not by a new read.
   // the selector is loaded on every change, a change back to
   // Normal included, so after such a return it reads level 2.
   always @(posedge CLK) begin
      if (SRST) begin
         last_target <= `PKG_NORMAL;
         IDLE_LEVEL_READ <= 1'b0;
         IDLE_LEVEL_SEL <= `LVL_2;
      end else begin
         last_target <= target;
         IDLE_LEVEL_READ <= (target != last_target) &&
            (target != `PKG_NORMAL);
         if (target != last_target) begin
            IDLE_LEVEL_SEL <= lvl_of(target);
         end
      end
   end

   // package machine; a break wake drops to Normal first
   // deep states step back through Stop Grant before Normal.
   // snoop and sleep are only honoured from Stop Grant.
   // a break still pending in Normal blocks re-entry: the cores
   // are being woken in that very cycle and their old states
   // would otherwise pull the package straight back down.
   always @* begin
      next_pkg = pkg;
      case (pkg)
         `PKG_NORMAL: begin
            if (stop_clk && !pbe && target != `PKG_NORMAL) begin
               next_pkg = `PKG_STOP_GRANT;
            end
         end
         `PKG_STOP_GRANT: begin
            if (pbe || !stop_clk || target == `PKG_NORMAL) begin
               next_pkg = `PKG_NORMAL;
            end else if (snoop_act) begin
               next_pkg = `PKG_STOP_GRANT_SNOOP;
            end else if (sleep_act) begin
               next_pkg = `PKG_SLEEP;
            end else if (target == `PKG_DEEP_SLEEP) begin
               next_pkg = `PKG_DEEP_SLEEP;
            end else if (target == `PKG_DEEPER_SLEEP) begin
               next_pkg = `PKG_DEEPER_SLEEP;
            end
         end
         `PKG_STOP_GRANT_SNOOP: begin
            // back once the snoop has been serviced
            if (!snoop_act) begin
               next_pkg = `PKG_STOP_GRANT;
            end
         end
         `PKG_SLEEP: begin
            if (!sleep_act) begin
               next_pkg = `PKG_STOP_GRANT;
            end
         end
         `PKG_DEEP_SLEEP, `PKG_DEEPER_SLEEP: begin
            // a break leaves before the cores resume; a target change follows a core already woken
            if (pbe || !stop_clk || target != pkg) begin
               next_pkg = `PKG_STOP_GRANT;
            end
         end
         default: next_pkg = `PKG_NORMAL;
      endcase
   end

   always @(posedge CLK) begin
      if (SRST) begin
         pkg <= `PKG_NORMAL;
      end else begin
         pkg <= next_pkg;
      end
   end

   // pending break: events or masked latched interrupts in stop clock
   // masked interrupts count as well, since the interrupt enable
   // flag only blocks servicing, not the need to wake.
   // the flag drops once the package is back in Normal or the
   // chipset has let go of stop clock; a new event in that same
   // cycle keeps it set only while stop clock is still asserted.
   always @(posedge CLK) begin
      if (SRST) begin
         pbe <= 1'b0;
      end else if (stop_clk && (|BREAK_EVENT || |MASKED_IRQ)) begin
         pbe <= 1'b1;
      end else if (pkg == `PKG_NORMAL || !stop_clk) begin
         pbe <= 1'b0; // set above wins over this clear
      end
   end

   // per-core stop grant acknowledge and deadline counters
   // each core sends one acknowledge per stop clock assertion.
   // the counter starts at the acknowledge response and grants
   // after a short fixed delay, far inside the 20 clock limit.
   // everything rearms when stop clock drops, so the next
   // assertion gets a fresh acknowledge.
   reg [4:0] grant_cnt [0:1];
   reg [1:0] ack_sent;
   reg [1:0] counting;
   integer i;

   // ack only with stop clock asserted grant by 20 clocks
   always @(posedge CLK) begin
      if (SRST) begin
         STOP_GRANT_ACK <= 2'h0;
         CORE_STOP_GRANTED <= 2'h0;
         ack_sent <= 2'h0;
         counting <= 2'h0;
         for (i = 0; i < 2; i = i + 1) begin
            grant_cnt[i] <= 5'h00;
         end
      end else begin
         for (i = 0; i < 2; i = i + 1) begin
            STOP_GRANT_ACK[i] <= stop_clk && !ack_sent[i];
            if (!stop_clk) begin
               ack_sent[i] <= 1'b0;
               counting[i] <= 1'b0;
               CORE_STOP_GRANTED[i] <= 1'b0;
               grant_cnt[i] <= 5'h00;
            end else begin
               if (!ack_sent[i]) begin
                  ack_sent[i] <= 1'b1;
               end
               if (ACK_RESPONSE[i] && !counting[i]) begin
                  counting[i] <= 1'b1;
                  grant_cnt[i] <= 5'h00;
               end else if (counting[i] && !CORE_STOP_GRANTED[i]) begin
                  grant_cnt[i] <= grant_cnt[i] + 5'h01;
                  if (grant_cnt[i] >= `STOP_GRANT_DELAY) begin
                     CORE_STOP_GRANTED[i] <= 1'b1;
                  end
               end
            end
         end
      end
   end

   // registered copies for the top outputs
   // every top output leaves from a flop; the state copies lag
   // the live state by one cycle, which the chipset tolerates
   // because it only reacts to the level read, the stop grant acknowledge and the break pin.
   always @(posedge CLK) begin
      if (SRST) begin
         PENDING_BREAK_EVENT_N <= 1'b1;
         PKG_STATE <= `PKG_NORMAL;
         CORE_STATE <= 6'h00;
      end else begin
         PENDING_BREAK_EVENT_N <= ~pbe;
         PKG_STATE <= pkg;
         CORE_STATE <= {st1, st0};
      end
   end
endmodule // dual_cpu_package_power_coordinator
`default_nettype wire

// ### testbench/power_coord_monitor.sv
// Purpose: port timing checks for the power coordinator
// Assumes: one clock, sync reset high
// Notes: bound to the top module
`timescale 1ns/100ps
`default_nettype none
`include "power_coord_regs.vh"
module power_coord_monitor (
   input wire CLK,
   input wire SRST,
   input wire [1:0] BREAK_EVENT,
   input wire [1:0] MASKED_IRQ,
   input wire [1:0] CORE_WAKE,
   input wire [1:0] ACK_RESPONSE,
   input wire STOP_CLOCK_REQUEST_N,
   input wire PENDING_BREAK_EVENT_N,
   input wire IDLE_LEVEL_READ,
   input wire [1:0] IDLE_LEVEL_SEL,
   input wire [1:0] STOP_GRANT_ACK,
   input wire [1:0] CORE_STOP_GRANTED,
   input wire [2:0] PKG_STATE,
   input wire [5:0] CORE_STATE
);
   wire [2:0] mn;
   // shallower core decides the package target
   assign mn = (CORE_STATE[2:0] < CORE_STATE[5:3]) ? CORE_STATE[2:0]
      : CORE_STATE[5:3];
   default clocking @(posedge CLK); endclocking
   default disable iff (SRST);
   // four samples cover the two-flop pin synchroniser
   sequence stop_held; !STOP_CLOCK_REQUEST_N [*4]; endsequence
   sequence stop_gone; STOP_CLOCK_REQUEST_N [*4]; endsequence
   property grant_p(i);
      ACK_RESPONSE[i] && !STOP_CLOCK_REQUEST_N |-> ##[1:20] CORE_STOP_GRANTED[i];
   endproperty
   break_sets_pbe_a: assert property (
      stop_held ##0 (|BREAK_EVENT) |-> ##[1:3] !PENDING_BREAK_EVENT_N)
      else $error("pending break missing after break event");
   masked_sets_pbe_a: assert property (
      stop_held ##0 (|MASKED_IRQ) |-> ##[1:3] !PENDING_BREAK_EVENT_N)
      else $error("pending break missing after masked interrupt");
   pbe_clears_a: assert property (
      stop_gone |=> PENDING_BREAK_EVENT_N)
      else $error("pending break held without stop clock");
   ack_needs_stop_a: assert property (
      |STOP_GRANT_ACK |-> $past(!STOP_CLOCK_REQUEST_N, 3))
      else $error("stop grant ack without stop clock");
   level_pulse_a: assert property (
      IDLE_LEVEL_READ |=> !IDLE_LEVEL_READ)
      else $error("level read longer than one cycle");
   level_sel_a: assert property (
      IDLE_LEVEL_READ |-> mn >= `CST_C2 && IDLE_LEVEL_SEL == mn - `CST_C2)
      else $error("level read selector wrong");
   pkg_normal_a: assert property (
      (mn < `CST_C2) [*2] |-> PKG_STATE == `PKG_NORMAL)
      else $error("package not normal with an active core");
   deep_c3_a: assert property (
      PKG_STATE inside {`PKG_DEEP_SLEEP, `PKG_DEEPER_SLEEP} |-> mn >= `CST_C3)
      else $error("deep package state with a shallow core");
   wake_c0_a: assert property (
      CORE_WAKE[0] |-> ##2 CORE_STATE[2:0] == `CST_C0)
      else $error("core0 not back in C0 after wake");
   grant0_a: assert property (grant_p(0))
      else $error("core0 stop grant late");
   grant1_a: assert property (grant_p(1))
      else $error("core1 stop grant late");
endmodule // power_coord_monitor
bind dual_cpu_package_power_coordinator power_coord_monitor
   u_power_coord_monitor (.CLK(CLK), .SRST(SRST), .BREAK_EVENT(BREAK_EVENT),
   .MASKED_IRQ(MASKED_IRQ), .CORE_WAKE(CORE_WAKE),
   .ACK_RESPONSE(ACK_RESPONSE), .STOP_CLOCK_REQUEST_N(STOP_CLOCK_REQUEST_N),
   .PENDING_BREAK_EVENT_N(PENDING_BREAK_EVENT_N),
   .IDLE_LEVEL_READ(IDLE_LEVEL_READ), .IDLE_LEVEL_SEL(IDLE_LEVEL_SEL),
   .STOP_GRANT_ACK(STOP_GRANT_ACK), .CORE_STOP_GRANTED(CORE_STOP_GRANTED),
   .PKG_STATE(PKG_STATE), .CORE_STATE(CORE_STATE));
`default_nettype wire

// ### testbench/chipset_model.sv
// Purpose: chipset side of the stop clock handshake
// Assumes: same clock as the coordinator
// Notes: drives sleep and snoop only as the bench requests
`timescale 1ns/100ps
`default_nettype none
module chipset_model (
   input wire logic clk,
   input wire logic srst,
   input wire logic en,
   input wire logic [3:0] lag,
   input wire logic lvl_read,
   input wire logic [1:0] sg_ack,
   input wire logic pbe_n,
   input wire logic sleep_in,
   input wire logic snoop_in,
   output logic stop_n,
   output logic [1:0] ack_resp,
   output logic sleep_n,
   output logic snoop
);
   logic [1:0] pend;
   logic [3:0] cnt;
   // sleep and snoop pins follow the bench's requests
   assign sleep_n = ~sleep_in;
   assign snoop = snoop_in;
   // lag sets how slowly acks get their response phase
   always @(posedge clk) begin
      if (srst) begin
         stop_n <= 1'b1;
         ack_resp <= 2'b00;
         pend <= 2'b00;
         cnt <= 4'h0;
      end else begin
         ack_resp <= 2'b00;
         pend <= pend | sg_ack;
         cnt <= (pend == 2'b00) ? 4'h0 : cnt + 4'h1;
         if (en && lvl_read) stop_n <= 1'b0;
         if (!pbe_n) stop_n <= 1'b1;
         if (pend != 2'b00 && cnt >= lag) begin
            ack_resp <= pend;
            pend <= sg_ack;
            cnt <= 4'h0;
         end
      end
   end
endmodule // chipset_model
`default_nettype wire

// ### testbench/tb_dual_cpu_package_power_coordinator.sv
// Purpose: self-checking bench for the power coordinator
// Assumes: chipset model answers the stop clock handshake
// Notes: expectations from integer model of the rules
`timescale 1ns/100ps
`default_nettype none
module tb_dual_cpu_package_power_coordinator;
   logic clk, srst, stop_n, sleep_n, snoop, pbe_n, lvl_rd, en;
   logic snoop_req, sleep_req;
   logic [1:0] halt, wreq, lreq, brk, mirq, wake, ack, lsel_o, sg_ack, granted;
   logic [5:0] hint, cstate;
   logic [3:0] lsel, lag;
   logic [8:0] cfg;
   logic [2:0] pkg;
   logic [1:0] seen_sel;
   integer fails, cmp_count, seed, i, j, k, n, mn, hits, st;
   dual_cpu_package_power_coordinator u_dual_cpu_package_power_coordinator (
      .CLK(clk), .SRST(srst), .HALT_REQ(halt), .WAIT_REQ(wreq),
      .WAIT_HINT(hint), .LVL_REQ(lreq), .LVL_SEL(lsel), .HINT_CFG(cfg),
      .BREAK_EVENT(brk), .MASKED_IRQ(mirq), .CORE_WAKE(wake),
      .ACK_RESPONSE(ack), .STOP_CLOCK_REQUEST_N(stop_n), .SLEEP_N(sleep_n),
      .SNOOP(snoop), .PENDING_BREAK_EVENT_N(pbe_n), .IDLE_LEVEL_READ(lvl_rd),
      .IDLE_LEVEL_SEL(lsel_o), .STOP_GRANT_ACK(sg_ack),
      .CORE_STOP_GRANTED(granted), .PKG_STATE(pkg), .CORE_STATE(cstate));
   chipset_model u_chipset_model (.clk(clk), .srst(srst), .en(en), .lag(lag),
      .lvl_read(lvl_rd), .sg_ack(sg_ack), .pbe_n(pbe_n),
      .sleep_in(sleep_req), .snoop_in(snoop_req), .stop_n(stop_n),
      .ack_resp(ack), .sleep_n(sleep_n), .snoop(snoop));
   // 100 MHz bus clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // inputs move 1 ns after the edge, clear of sampling
   task tick(input integer c);
      repeat (c) @(posedge clk);
      #1;
   endtask
   task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
         fails = fails + 1;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task wake_all;
      wake = 2'b11;
      tick(1);
      wake = 2'b00;
      tick(2);
   endtask
   task wrap_up;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // watchdog: whole run needs about 500 cycles
   initial begin
      #100000;
      fails = fails + 1;
      wrap_up;
   end
   initial begin
      fails = 0;
      cmp_count = 0;
      seed = 19;
      srst = 1'b1;
      {halt, wreq, lreq, brk, mirq, wake} = 12'h000;
      hint = 6'h00;
      lsel = 4'h0;
      cfg = 9'h000;
      en = 1'b0;
      snoop_req = 1'b0;
      sleep_req = 1'b0;
      lag = 4'h0;
      tick(2);
      srst = 1'b0;
      check("pbe_n", 8'(pbe_n), 8'h01);
      check("pkg", 8'(pkg), 8'h00);
      // every pair of wait hints 0 to 5 against the coordination table
      for (i = 0; i < 6; i++) for (j = 0; j < 6; j++) begin
         wake_all;
         wreq = 2'b11;
         hint = {3'(j), 3'(i)};
         tick(1);
         wreq = 2'b00;
         hits = 0;
         repeat (4) begin
            tick(1);
            if (lvl_rd === 1'b1) begin
               hits++;
               seen_sel = lsel_o;
            end
         end
         mn = (i < j) ? i : j;
         check("core_state", 8'(cstate), 8'(j * 8 + i));
         check("level_reads", 8'(hits), 8'(mn >= 3));
         if (mn >= 3) check("level_sel", 8'(seen_sel), 8'(mn - 3));
      end
      $display("hint table test done");
      // level reads through random hint setting, then a halt that must bounce unless the level read left the core in C0
      for (k = 0; k < 6; k++) begin
         wake_all;
         cfg = 9'($random(seed));
         lreq = 2'b11;
         lsel = {2'(k % 3), 2'(k % 3)};
         tick(1);
         lreq = 2'b00;
         halt = 2'b11;
         tick(1);
         halt = 2'b00;
         tick(2);
         st = (cfg >> (3 * (k % 3))) & 7;
         if (st > 5) st = 5;
         if (st == 0) st = 1;
         check("level_state", 8'(cstate), 8'(st * 9));
      end
      $display("level read test done");
      // stop clock handshake, break and wake for C2, C3 and C4
      en = 1'b1;
      cfg = 9'h163;
      for (k = 0; k < 3; k++) begin
         wake_all;
         lag = 4'($random(seed)) & 4'h7;
         lreq = 2'b11;
         lsel = {2'(k), 2'(k)};
         tick(1);
         lreq = 2'b00;
         st = (k == 0) ? 1 : k + 3;
         n = 0;
         while ((granted !== 2'b11 || pkg !== 3'(st)) && n < 80) begin
            tick(1);
            n++;
         end
         check("granted", 8'(granted), 8'h03);
         check("pkg_low", 8'(pkg), 8'(st));
         if (k == 0) begin
            // snoop and sleep detours out of Stop Grant
            snoop_req = 1'b1;
            n = 0;
            while (pkg !== 3'h2 && n < 8) begin
               tick(1);
               n++;
            end
            check("pkg_snoop", 8'(pkg), 8'h02);
            snoop_req = 1'b0;
            n = 0;
            while (pkg !== 3'h1 && n < 8) begin
               tick(1);
               n++;
            end
            check("pkg_snoop_back", 8'(pkg), 8'h01);
            sleep_req = 1'b1;
            n = 0;
            while (pkg !== 3'h3 && n < 8) begin
               tick(1);
               n++;
            end
            check("pkg_sleep", 8'(pkg), 8'h03);
            sleep_req = 1'b0;
            n = 0;
            while (pkg !== 3'h1 && n < 8) begin
               tick(1);
               n++;
            end
            check("pkg_sleep_back", 8'(pkg), 8'h01);
         end
         if (k == 1) mirq = 2'b01;
         else brk = 2'b10;
         tick(1);
         {mirq, brk} = 4'h0;
         n = 0;
         while (pbe_n !== 1'b0 && n < 5) begin
            tick(1);
            n++;
         end
         check("pbe_n", 8'(pbe_n), 8'h00);
         n = 0;
         while ((cstate !== 6'h00 || pkg !== 3'h0) && n < 80) begin
            tick(1);
            n++;
         end
         check("woken", 8'(cstate), 8'h00);
         check("pkg_back", 8'(pkg), 8'h00);
         tick(8);
      end
      $display("stop clock test done");
      wrap_up;
   end
endmodule // tb_dual_cpu_package_power_coordinator
`default_nettype wire
